/* src/gain_decode.sv */
// Gain decoder: splits a half-dB gain code over the three stages
`timescale 1ns/1ps
`default_nettype none
module gain_decode
    import vga_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [6:0] code,
    output gain_word_t word
);

    gain_word_t word_r;
    gain_word_t word_nxt;

    // Fill first stage first, keeps noise figure lowest
    always_comb begin
        logic [6:0] c;
        logic [5:0] rest;
        c = code;
        rest = 6'h00;
        word_nxt = word_r;
        if (c > GAIN_CODE_MAX) begin
            c = GAIN_CODE_MAX; // Out-of-range codes clamp to top gain
        end
        if (c >= 7'(2 * STAGE1_STEP)) begin
            word_nxt.stage1_sel = 3'h4;
            rest = 6'(c - 7'(2 * STAGE1_STEP));
        end else if (c >= STAGE1_STEP) begin
            word_nxt.stage1_sel = 3'h2;
            rest = 6'(c - STAGE1_STEP);
        end else begin
            word_nxt.stage1_sel = 3'h1;
            rest = c[5:0];
        end
        if (rest > STAGE2_MAX) begin
            word_nxt.stage3_high = 1'b1;
            word_nxt.stage2_code = 5'(rest - STAGE2_MAX);
        end else begin
            word_nxt.stage3_high = 1'b0;
            word_nxt.stage2_code = rest[4:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            word_r <= '{stage3_high: 1'b0, stage1_sel: 3'h1, stage2_code: 5'h00};
        end else begin
            word_r <= word_nxt;
        end
    end

    assign word = word_r;

endmodule : gain_decode
`default_nettype wire

/* src/vga_ctrl_pkg.sv */
// Constants and types for the dual-channel gain amplifier serial control block
// Overview of operation
// - Read phase shifts data, address, chip id out
// - Read-phase input frame commits like any write
// - Parallel gain port always passes the decoder
// - Enable register: I bit0, Q bit1, reset one
// - Amplifier bias bits 1:0, reset 01
// - Driver bias bits 3:2, reset 01
// - Bit 4 selects low input impedance, reset 1
// - Bit 5 selects serial gain source, reset 0
// - Bit 6 bypasses gain decoder, serial only
// - Bit 7 disables gain deglitching, reset 0
// - Decoded gain code 0 to 80 half-dB steps
// - Undecoded bits 7:5 one-hot first stage
// - Undecoded bit 8 sets third stage
// - Undecoded bits 4:0 set second stage
// - Parallel source ignores gain register entirely
// - Gain register resets to all zero
// - Capture 24 data then 5 address bits, MSB first
// - Host drives on falling, device samples rising
// - Writing 20h then 00h to register 0 resets
package vga_ctrl_pkg;

    // Register indices on the serial port
    localparam logic [4:0] REG_READ_ADDR = 5'h00;
    localparam logic [4:0] REG_CHANNEL_ENABLE = 5'h01;
    localparam logic [4:0] REG_AMPLIFIER_SETTINGS = 5'h02;
    localparam logic [4:0] REG_GAIN_SETTING = 5'h03;

    // Field positions
    localparam int EN_I_BIT = 0;
    localparam int EN_Q_BIT = 1;
    localparam int AMP_BIAS_LSB = 0;
    localparam int DRV_BIAS_LSB = 2;
    localparam int LOW_IMP_BIT = 4;
    localparam int SERIAL_SRC_BIT = 5;
    localparam int DECODE_BYPASS_BIT = 6;
    localparam int DEGLITCH_OFF_BIT = 7;

    // Reset values
    localparam logic [23:0] READ_ADDR_RST = 24'h00_0000;
    localparam logic [3:0] CHANNEL_ENABLE_RST = 4'h3;
    localparam logic [7:0] AMPLIFIER_SETTINGS_RST = 8'h15;
    localparam logic [8:0] GAIN_SETTING_RST = 9'h000;

    // Soft reset key sequence
    localparam logic [23:0] SOFT_RESET_ARM = 24'h00_0020;
    localparam logic [23:0] SOFT_RESET_FIRE = 24'h00_0000;

    // Frame layout
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_LAST = 6'h1F;
    localparam logic [5:0] FRAME_DONE = 6'h20;

    // Gain decoder limits, in half-dB units
    localparam logic [6:0] GAIN_CODE_MAX = 7'h50;
    localparam logic [6:0] STAGE1_STEP = 7'h14;
    localparam logic [5:0] STAGE2_MAX = 6'h14;

    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEGLITCH_NS = 100;
    localparam int DEGLITCH_CYCLES_INT = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] DEGLITCH_CYCLES = 3'(DEGLITCH_CYCLES_INT);

    // Stage settings applied to both channels
    typedef struct packed {
        logic stage3_high;
        logic [2:0] stage1_sel;
        logic [4:0] stage2_code;
    } gain_word_t;

    // Received serial frame
    typedef struct packed {
        logic [23:0] data;
        logic [4:0] addr;
        logic [2:0] chip;
    } frame_t;

    typedef enum logic [1:0] {
        SR_IDLE = 2'b01,
        SR_ARMED = 2'b10
    } soft_reset_t;

endpackage : vga_ctrl_pkg

/* src/vga_gain_serial_control.sv */
// Serial control slave and register bank of the dual-channel gain amplifier
`timescale 1ns/1ps
`default_nettype none
module vga_gain_serial_control
    import vga_ctrl_pkg::*;
#(
    parameter logic [2:0] CHIP_ADDR = 3'h5 // Arbitrary value
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic select_low,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic [6:0] parallel_gain_pins,
    output logic i_enable,
    output logic q_enable,
    output logic [1:0] amp_bias,
    output logic [1:0] drv_bias,
    output logic low_input_impedance_sel,
    output gain_word_t applied_gain
);

    // Link-side shift state, cleared whenever select is high
    typedef struct packed {
        logic [5:0] cnt;
        logic sdo;
        logic oe;
    } link_state_t;

    // Link-side capture, kept after the frame so the core can read it
    typedef struct packed {
        logic [31:0] rx;
        logic full;
    } capture_state_t;

    // Core-side state on clk
    typedef struct packed {
        logic sel_s1;
        logic sel_s2;
        logic sel_s3;
        logic full_s1;
        logic full_s2;
        logic [6:0] pins_s1;
        logic [6:0] pins_s2;
        logic [23:0] read_addr;
        logic [3:0] channel_enable;
        logic [7:0] amplifier_settings;
        logic [8:0] gain_setting;
        soft_reset_t sr_state;
        logic [31:0] tx_word;
        gain_word_t raw_gain;
        gain_word_t last_cand;
        logic [2:0] stable_cnt;
        gain_word_t applied;
    } core_state_t;

    link_state_t ls_r;
    link_state_t ls_nxt;
    capture_state_t cap_r;
    capture_state_t cap_nxt;
    core_state_t st_r;
    core_state_t st_nxt;

    logic link_clear;
    logic [4:0] tx_index;
    logic [6:0] decode_in;
    gain_word_t decoded_gain;
    gain_word_t candidate;
    frame_t frame;
    logic frame_end;
    logic commit;

    // ---------------- Link domain ----------------

    // Select high ends a frame at once; sclk may stop right after
    assign link_clear = reset | select_low;
    assign tx_index = 5'(FRAME_LAST - ls_r.cnt);

    // Output shifter, one bit per rising edge from the first one
    always_comb begin
        ls_nxt = ls_r;
        ls_nxt.oe = 1'b1;
        if (ls_r.cnt < FRAME_DONE) begin
            ls_nxt.cnt = ls_r.cnt + 6'h01;
            ls_nxt.sdo = st_r.tx_word[tx_index];
        end else begin
            ls_nxt.sdo = 1'b0;
        end
    end

    always_ff @(posedge sclk or posedge link_clear) begin
        if (link_clear) begin
            ls_r <= '0;
        end else begin
            ls_r <= ls_nxt;
        end
    end

    // Input shifter; full marks exactly 32 bits in the last frame that had sclk edges
    always_comb begin
        cap_nxt = cap_r;
        cap_nxt.rx = {cap_r.rx[30:0], sdi};
        if (ls_r.cnt == FRAME_LAST) begin
            cap_nxt.full = 1'b1;
        end else if (ls_r.cnt == 6'h00 || ls_r.cnt == FRAME_DONE) begin
            cap_nxt.full = 1'b0; // Frames of 1 to 31 or over 32 bits never commit
        end
    end

    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            cap_r <= '0;
        end else begin
            cap_r <= cap_nxt;
        end
    end

    // ---------------- Core domain ----------------

    // Parallel port always goes through the decoder
    assign decode_in = st_r.amplifier_settings[SERIAL_SRC_BIT] ?
                       st_r.gain_setting[6:0] : st_r.pins_s2;

    gain_decode u_gain_decode (
        .clk(clk),
        .reset(reset),
        .code(decode_in),
        .word(decoded_gain)
    );

    // Bypass only counts when the serial source is chosen
    assign candidate = (st_r.amplifier_settings[SERIAL_SRC_BIT] &&
                        st_r.amplifier_settings[DECODE_BYPASS_BIT]) ?
                       st_r.raw_gain : decoded_gain;

    // Captured word is stable here: sclk is idle once select is high
    assign frame = frame_t'(cap_r.rx);
    assign frame_end = st_r.sel_s2 & ~st_r.sel_s3;
    assign commit = frame_end & st_r.full_s2 & (frame.chip == CHIP_ADDR);

    always_comb begin
        st_nxt = st_r;

        // Synchronisers for select, frame-full flag and gain pins
        st_nxt.sel_s1 = select_low;
        st_nxt.sel_s2 = st_r.sel_s1;
        st_nxt.sel_s3 = st_r.sel_s2;
        st_nxt.full_s1 = cap_r.full;
        st_nxt.full_s2 = st_r.full_s1;
        st_nxt.pins_s1 = parallel_gain_pins;
        st_nxt.pins_s2 = st_r.pins_s1;

        // Every complete frame for this chip id is a write, read phase included
        if (commit) begin
            unique case (frame.addr)
                REG_READ_ADDR: begin
                    st_nxt.read_addr = frame.data;
                end
                REG_CHANNEL_ENABLE: begin
                    st_nxt.channel_enable = frame.data[3:0];
                end
                REG_AMPLIFIER_SETTINGS: begin
                    st_nxt.amplifier_settings = frame.data[7:0];
                end
                REG_GAIN_SETTING: begin
                    st_nxt.gain_setting = frame.data[8:0];
                end
                default: begin
                    st_nxt.read_addr = st_r.read_addr; // Unmapped address, nothing stored
                end
            endcase

            // Soft reset key; any other frame drops the arm
            unique case (st_r.sr_state)
                SR_IDLE: begin
                    if (frame.addr == REG_READ_ADDR && frame.data == SOFT_RESET_ARM) begin
                        st_nxt.sr_state = SR_ARMED;
                    end
                end
                SR_ARMED: begin
                    st_nxt.sr_state = SR_IDLE;
                    if (frame.addr == REG_READ_ADDR && frame.data == SOFT_RESET_FIRE) begin
                        st_nxt.read_addr = READ_ADDR_RST;
                        st_nxt.channel_enable = CHANNEL_ENABLE_RST;
                        st_nxt.amplifier_settings = AMPLIFIER_SETTINGS_RST;
                        st_nxt.gain_setting = GAIN_SETTING_RST;
                    end else if (frame.addr == REG_READ_ADDR &&
                                 frame.data == SOFT_RESET_ARM) begin
                        st_nxt.sr_state = SR_ARMED;
                    end
                end
                default: begin
                    st_nxt.sr_state = SR_IDLE;
                end
            endcase
        end

        // Read-back word for the next frame, chosen by register 0
        unique case (st_nxt.read_addr[4:0])
            REG_READ_ADDR: begin
                st_nxt.tx_word = {st_nxt.read_addr, 5'h00, CHIP_ADDR};
            end
            REG_CHANNEL_ENABLE: begin
                st_nxt.tx_word = {20'h0_0000, st_nxt.channel_enable,
                                  REG_CHANNEL_ENABLE, CHIP_ADDR};
            end
            REG_AMPLIFIER_SETTINGS: begin
                st_nxt.tx_word = {16'h0000, st_nxt.amplifier_settings,
                                  REG_AMPLIFIER_SETTINGS, CHIP_ADDR};
            end
            REG_GAIN_SETTING: begin
                st_nxt.tx_word = {15'h0000, st_nxt.gain_setting,
                                  REG_GAIN_SETTING, CHIP_ADDR};
            end
            default: begin
                st_nxt.tx_word = {24'h00_0000, st_nxt.read_addr[4:0], CHIP_ADDR};
            end
        endcase

        // Undecoded path, registered to line up with the decoder
        st_nxt.raw_gain = gain_word_t'(st_r.gain_setting);

        // Deglitch: hold off until candidate is steady long enough
        st_nxt.last_cand = candidate;
        if (candidate != st_r.last_cand) begin
            st_nxt.stable_cnt = 3'h0;
        end else if (st_r.stable_cnt < DEGLITCH_CYCLES) begin
            st_nxt.stable_cnt = st_r.stable_cnt + 3'h1;
        end
        if (st_r.amplifier_settings[DEGLITCH_OFF_BIT]) begin
            st_nxt.applied = candidate;
        end else if (st_r.stable_cnt == DEGLITCH_CYCLES) begin
            st_nxt.applied = st_r.last_cand;
        end
    end

    // Power-on defaults; gain register starts at minimum gain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '{sel_s1: 1'b1, sel_s2: 1'b1, sel_s3: 1'b1,
                      full_s1: 1'b0, full_s2: 1'b0,
                      pins_s1: 7'h00, pins_s2: 7'h00,
                      read_addr: READ_ADDR_RST,
                      channel_enable: CHANNEL_ENABLE_RST,
                      amplifier_settings: AMPLIFIER_SETTINGS_RST,
                      gain_setting: GAIN_SETTING_RST,
                      sr_state: SR_IDLE,
                      tx_word: {READ_ADDR_RST, 5'h00, CHIP_ADDR},
                      raw_gain: '0,
                      last_cand: '{stage3_high: 1'b0, stage1_sel: 3'h1, stage2_code: 5'h00},
                      stable_cnt: 3'h0,
                      applied: '{stage3_high: 1'b0, stage1_sel: 3'h1, stage2_code: 5'h00}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state flops
    assign sdo = ls_r.sdo;
    assign sdo_oe = ls_r.oe;
    assign i_enable = st_r.channel_enable[EN_I_BIT];
    assign q_enable = st_r.channel_enable[EN_Q_BIT];
    assign amp_bias = st_r.amplifier_settings[AMP_BIAS_LSB +: 2];
    assign drv_bias = st_r.amplifier_settings[DRV_BIAS_LSB +: 2];
    assign low_input_impedance_sel = st_r.amplifier_settings[LOW_IMP_BIT];
    assign applied_gain = st_r.applied;

endmodule : vga_gain_serial_control
`default_nettype wire

/* tb/host_model.sv */
// Host controller model that masters the four-wire serial port
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter logic [2:0] CHIP = 3'h5 // Arbitrary value
) (
    output logic sclk,
    output logic select_low,
    output logic sdi,
    input wire logic sdo
);
    // Idle: clock parked low, select high
    initial begin
        sclk = 1'b0;
        select_low = 1'b1;
        sdi = 1'b0;
    end
    // One frame, data changed on falling edges, chip bits last
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        #37;
        select_low = 1'b0;
        sdi = tx[31];
        for (int i = 31; i >= 0; i--) begin
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
            rx[i] = sdo; // Captured on the falling edge
            if (i > 0) begin
                sdi = tx[i-1];
            end
        end
        #20 select_low = 1'b1; // After 32nd fall, before next rise
        sdi = ~tx[0]; // Released line shows no stale bit
        #403; // Gap lets commit settle; frame length stays a multiple of 10 ns
    endtask : xfer
    // Register write
    task automatic wr(input logic [4:0] a, input logic [23:0] d);
        logic [31:0] rx;
        xfer({d, a, CHIP}, rx);
    endtask : wr
    // Two-frame read; second frame normally re-addresses register 0
    task automatic rd(input logic [4:0] a, input logic [23:0] d2, input logic [4:0] a2,
                      output logic [31:0] rx);
        logic [31:0] dummy;
        xfer({19'h0_0000, a, 5'h00, CHIP}, dummy); // Address into register 0
        xfer({d2, a2, CHIP}, rx);
    endtask : rd
endmodule : host_model
`default_nettype wire

/* tb/vga_gain_serial_control_checker.sv */
// Port-level assertions for the gain amplifier serial control block
`timescale 1ns/1ps
`default_nettype none
module vga_gain_serial_control_checker
    import vga_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic select_low,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic [6:0] parallel_gain_pins,
    input wire logic i_enable,
    input wire logic q_enable,
    input wire logic [1:0] amp_bias,
    input wire logic [1:0] drv_bias,
    input wire logic low_input_impedance_sel,
    input wire gain_word_t applied_gain
);
    logic [6:0] cfg;
    logic [2:0] low_cnt_r;
    // Config outputs watched as one word
    assign cfg = {i_enable, q_enable, amp_bias, drv_bias, low_input_impedance_sel};
    // Core cycles spent inside a frame, saturating at seven
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            low_cnt_r <= 3'h0;
        end else begin
            low_cnt_r <= select_low ? 3'h0 : low_cnt_r + 3'(low_cnt_r != 3'h7);
        end
    end
    // Past value used: select may rise in the same step as the clock
    AST_SDO_IDLE: assert property (@(posedge clk) disable iff (reset)
        select_low && $past(select_low) |-> !sdo_oe && !sdo)
        else $error("sdo driven outside a frame");
    AST_OE_FRAME: assert property (@(negedge sclk) disable iff (reset)
        !select_low |-> sdo_oe)
        else $error("sdo not driven inside a frame");
    AST_OE_RISE: assert property (@(posedge clk) disable iff (reset)
        $rose(sdo_oe) |-> sclk && !select_low)
        else $error("sdo enable rose without a serial clock rise");
    AST_OE_FALL: assert property (@(posedge clk) disable iff (reset)
        $fell(sdo_oe) |-> select_low)
        else $error("sdo enable fell while still selected");
    AST_SDO_HOLD: assert property (@(posedge clk) disable iff (reset)
        !sclk && $past(!sclk) && !select_low |-> $stable(sdo))
        else $error("sdo changed while serial clock low");
    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> cfg == 7'h6B && applied_gain == 9'h020 && !sdo_oe)
        else $error("outputs wrong after reset release");
    AST_CFG_AFTER_SELECT: assert property (@(posedge clk) disable iff (reset)
        $changed(cfg) |-> $past(select_low) && $past(select_low, 2))
        else $error("config changed too soon after select");
    AST_CFG_STABLE_IN_FRAME: assert property (@(posedge clk) disable iff (reset)
        low_cnt_r == 3'h7 |-> $stable(cfg))
        else $error("config changed during a frame");
    // Main scenarios reached
    COV_READ: cover property (@(posedge clk) disable iff (reset) $rose(sdo_oe));
    COV_GAIN: cover property (@(posedge clk) disable iff (reset) $changed(applied_gain));
    COV_CFG: cover property (@(posedge clk) disable iff (reset) $changed(cfg));
endmodule : vga_gain_serial_control_checker
bind vga_gain_serial_control vga_gain_serial_control_checker i_chk (.clk(clk), .reset(reset),
    .sclk(sclk), .select_low(select_low), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .parallel_gain_pins(parallel_gain_pins), .i_enable(i_enable), .q_enable(q_enable),
    .amp_bias(amp_bias), .drv_bias(drv_bias),
    .low_input_impedance_sel(low_input_impedance_sel), .applied_gain(applied_gain));
`default_nettype wire

/* tb/vga_gain_serial_control_test.sv */
// Self-checking testbench for the gain amplifier serial control block
`timescale 1ns/1ps
`default_nettype none
module vga_gain_serial_control_test
    import vga_ctrl_pkg::*;
;
    localparam logic [2:0] CHIP = 3'h5; // Arbitrary value
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] parallel_gain_pins = 7'h00;
    logic sclk, select_low, sdi, sdo, sdo_oe, i_enable, q_enable, low_input_impedance_sel;
    logic [1:0] amp_bias, drv_bias;
    gain_word_t applied_gain;
    logic [31:0] rx;
    int miscompares = 0;
    int comparisons = 0;
    always #25 clk = ~clk;
    vga_gain_serial_control #(.CHIP_ADDR(CHIP)) i_dut (.clk(clk), .reset(reset), .sclk(sclk),
        .select_low(select_low), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .parallel_gain_pins(parallel_gain_pins), .i_enable(i_enable), .q_enable(q_enable),
        .amp_bias(amp_bias), .drv_bias(drv_bias),
        .low_input_impedance_sel(low_input_impedance_sel), .applied_gain(applied_gain));
    host_model #(.CHIP(CHIP)) i_host (.sclk(sclk), .select_low(select_low), .sdi(sdi),
        .sdo(sdo));
    // Compare a read-back word or any packed value
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    // Compare config pins and applied gain after settling
    task automatic chk_pins(input logic [6:0] c, input logic [8:0] g);
        repeat (14) @(posedge clk);
        chk_word({i_enable, q_enable, amp_bias, drv_bias, low_input_impedance_sel,
                  applied_gain}, {c, g});
    endtask : chk_pins
    task automatic rdchk(input logic [4:0] a, input logic [23:0] d);
        i_host.rd(a, 24'(a), REG_READ_ADDR, rx);
        chk_word(rx, {d, a, CHIP});
    endtask : rdchk
    // Own model of the decoder allocation
    function automatic logic [8:0] dec(input logic [6:0] c);
        logic [6:0] r;
        logic [2:0] s;
        s = (c >= 7'h28) ? 3'b100 : (c >= 7'h14) ? 3'b010 : 3'b001;
        r = (c >= 7'h28) ? c - 7'h28 : (c >= 7'h14) ? c - 7'h14 : c;
        return (r > 7'h14) ? {1'b1, s, 5'(r - 7'h14)} : {1'b0, s, r[4:0]};
    endfunction : dec
    task automatic t_defaults;
        chk_pins(7'h6B, 9'h020);
        rdchk(5'h01, 24'h00_0003);
        rdchk(5'h02, 24'h00_0015);
        rdchk(5'h03, 24'h00_0000);
        rdchk(5'h07, 24'h00_0000);
        $display("defaults done");
    endtask : t_defaults
    task automatic t_config;
        i_host.wr(REG_AMPLIFIER_SETTINGS, 24'h00_000A);
        chk_pins(7'h74, 9'h020);
        i_host.wr(REG_CHANNEL_ENABLE, 24'h00_000E);
        chk_pins(7'h34, 9'h020);
        rdchk(5'h01, 24'h00_000E);
        i_host.rd(5'h02, 24'h00_0001, REG_CHANNEL_ENABLE, rx);
        chk_word(rx, {24'h00_000A, 5'h02, CHIP});
        chk_pins(7'h54, 9'h020);
        i_host.xfer({24'h00_0000, REG_CHANNEL_ENABLE, CHIP ^ 3'h1}, rx);
        chk_pins(7'h54, 9'h020);
        $display("config done");
    endtask : t_config
    task automatic t_parallel;
        logic [6:0] codes [7];
        codes = '{7'h00, 7'h13, 7'h14, 7'h27, 7'h28, 7'h4F, 7'h50};
        foreach (codes[k]) begin
            @(posedge clk) parallel_gain_pins <= codes[k];
            chk_pins(7'h54, dec(codes[k]));
        end
        i_host.wr(REG_GAIN_SETTING, 24'h00_01FF);
        chk_pins(7'h54, dec(7'h50));
        $display("parallel done");
    endtask : t_parallel
    // One-cycle pin glitch: blocked, then passed with deglitch off
    task automatic t_glitch;
        int seen;
        for (int m = 0; m < 2; m++) begin
            seen = 0;
            @(posedge clk) parallel_gain_pins <= 7'h00;
            @(posedge clk) parallel_gain_pins <= 7'h50;
            repeat (14) begin
                @(negedge clk); // Sample away from the launching edge
                seen += int'(applied_gain !== dec(7'h50));
            end
            chk_word(32'(seen != 0), 32'(m));
            i_host.wr(REG_AMPLIFIER_SETTINGS, 24'h00_008A);
        end
        $display("glitch done");
    endtask : t_glitch
    task automatic t_serial;
        logic [8:0] raw [4];
        raw = '{9'h02A, 9'h054, 9'h194, 9'h180};
        i_host.wr(REG_GAIN_SETTING, 24'h00_001E);
        i_host.wr(REG_AMPLIFIER_SETTINGS, 24'h00_002A);
        chk_pins(7'h54, dec(7'h1E));
        i_host.wr(REG_AMPLIFIER_SETTINGS, 24'h00_006A);
        foreach (raw[k]) begin
            i_host.wr(REG_GAIN_SETTING, 24'(raw[k]));
            chk_pins(7'h54, raw[k]);
        end
        $display("serial done");
    endtask : t_serial
    task automatic t_soft;
        i_host.wr(REG_READ_ADDR, SOFT_RESET_ARM);
        i_host.wr(REG_READ_ADDR, SOFT_RESET_FIRE);
        chk_pins(7'h6B, dec(7'h50));
        rdchk(5'h03, 24'h00_0000);
        $display("soft reset done");
    endtask : t_soft
    task automatic summarize;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    // Watchdog well beyond the expected run of about 180 us
    initial begin
        #1_000_000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        t_defaults();
        t_config();
        t_parallel();
        t_glitch();
        t_serial();
        t_soft();
        summarize();
    end
endmodule : vga_gain_serial_control_test
`default_nettype wire
